// ---- core/modulator_clock_and_decimation_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module modulator_clock_and_decimation_control #(
  parameter int MEAS_CYCLES = mod_clock_pkg::MEAS_WINDOW_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic mainClockIn,
  input wire logic [mod_clock_pkg::CHANNELS-1:0] modulatorBitIn,
  input wire logic [1:0] powerModeSelect,
  input wire logic [1:0] dividerSelect,
  input wire logic [3:0] supplyBandCode,
  input wire logic [2:0] osrSelect,
  input wire logic turboSelect,
  input wire logic standby,
  output logic modulatorClock,
  output logic [mod_clock_pkg::CHANNELS-1:0] modulatorBits,
  output logic highResolutionMode,
  output logic lowPowerMode,
  output logic [mod_clock_pkg::KHZ_W-1:0] supplyBandLowKhz,
  output logic [mod_clock_pkg::KHZ_W-1:0] supplyBandHighKhz,
  output logic [mod_clock_pkg::KHZ_W-1:0] modulatorFrequencyKhz,
  output logic supplySyncMismatch,
  output logic [mod_clock_pkg::RATE_W-1:0] outputRateSps,
  output logic filterSettled,
  output logic sampleOverrun,
  output logic sampleValid,
  input wire logic sampleReady,
  output logic [mod_clock_pkg::SAMPLE_W-1:0] sampleData
);
  localparam int CH = mod_clock_pkg::CHANNELS;
  localparam int WW = mod_clock_pkg::WORD_W;

  // ==========================================================
  // helpers
  function automatic logic [mod_clock_pkg::CNT_W-1:0] lowMask(input logic [3:0] lg);
    lowMask = mod_clock_pkg::CNT_W'((1 << lg) - 1);
  endfunction : lowMask

  // align a filter result to a common full scale, clip the all-ones case
  function automatic logic [WW-1:0] scaleWord(
    input logic [mod_clock_pkg::ACC_W-1:0] v,
    input logic [5:0] sh
  );
    logic [mod_clock_pkg::ACC_W-1:0] aligned;
    aligned = v << sh;
    scaleWord = aligned[mod_clock_pkg::ACC_W-1] ? {WW{1'b1}}
                                                : aligned[mod_clock_pkg::ACC_W-2 -: WW];
  endfunction : scaleWord

  // ==========================================================
  // pin synchronisers
  logic [1:0] mainSync_r;
  logic mainPrev_r;
  logic mainRise;
  logic [CH-1:0] bitMeta_r;
  logic [CH-1:0] bitSync_r;

  // main clock pin is asynchronous to clk_sys, two stages before use
  // reset high: a pin already high at release must not count as a rise
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mainSync_r <= 2'h3;
      mainPrev_r <= 1'b1;
    end else begin
      mainSync_r <= {mainSync_r[0], mainClockIn};
      mainPrev_r <= mainSync_r[1];
    end
  end
  assign mainRise = mainSync_r[1] & ~mainPrev_r;

  // bitstream from the isolation receiver
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bitMeta_r <= '0;
      bitSync_r <= '0;
    end else begin
      bitMeta_r <= modulatorBitIn;
      bitSync_r <= bitMeta_r;
    end
  end

  // ==========================================================
  // modulator clock divider
  logic [2:0] halfRatio;
  logic [2:0] divCount_r;
  logic divWrap;
  logic modTick;

  assign halfRatio = mod_clock_pkg::HALF_DIV[dividerSelect];
  // >= lets a ratio change mid-count finish at once instead of wrapping
  assign divWrap = (divCount_r >= halfRatio - 3'h1);
  assign modTick = mainRise & divWrap & ~modulatorClock;

  // toggling every half ratio of main edges keeps the duty at 50%
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      divCount_r <= 3'h0;
      modulatorClock <= 1'b0;
    end else if (mainRise) begin
      if (divWrap) begin
        divCount_r <= 3'h0;
        modulatorClock <= ~modulatorClock;
      end else begin
        divCount_r <= divCount_r + 3'h1;
      end
    end
  end

  // one bitstream sample per channel per modulator cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      modulatorBits <= '0;
    end else if (modTick) begin
      modulatorBits <= bitSync_r;
    end
  end

  // ==========================================================
  // power mode and supply band
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      highResolutionMode <= 1'b0;
      lowPowerMode <= 1'b1;
    end else begin
      highResolutionMode <= powerModeSelect[mod_clock_pkg::PWR_HR_BIT];
      lowPowerMode <= ~powerModeSelect[mod_clock_pkg::PWR_HR_BIT];
    end
  end

  // band limits follow the code, the host is trusted to set it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      supplyBandLowKhz <= mod_clock_pkg::BAND_LOW_KHZ[0];
      supplyBandHighKhz <= mod_clock_pkg::BAND_HIGH_KHZ[0];
    end else begin
      supplyBandLowKhz <= mod_clock_pkg::BAND_LOW_KHZ[supplyBandCode];
      supplyBandHighKhz <= mod_clock_pkg::BAND_HIGH_KHZ[supplyBandCode];
    end
  end

  // ==========================================================
  // modulator frequency measurement over a fixed window
  logic [mod_clock_pkg::MEAS_W-1:0] windowCount_r;
  logic [mod_clock_pkg::KHZ_W-1:0] tickCount_r;
  logic windowEnd;

  assign windowEnd = (windowCount_r == mod_clock_pkg::MEAS_W'(MEAS_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      windowCount_r <= '0;
      tickCount_r <= '0;
      modulatorFrequencyKhz <= '0;
    end else if (windowEnd) begin
      windowCount_r <= '0;
      tickCount_r <= mod_clock_pkg::KHZ_W'(modTick);
      modulatorFrequencyKhz <= tickCount_r;
    end else begin
      windowCount_r <= windowCount_r + 1'b1;
      if (modTick && tickCount_r != {mod_clock_pkg::KHZ_W{1'b1}}) begin
        tickCount_r <= tickCount_r + 1'b1;
      end
    end
  end

  // flags a band code that does not cover the measured frequency
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      supplySyncMismatch <= 1'b0;
    end else begin
      supplySyncMismatch <= (modulatorFrequencyKhz < supplyBandLowKhz) ||
                            (modulatorFrequencyKhz > supplyBandHighKhz);
    end
  end

  // ==========================================================
  // oversampling configuration, sampled only in standby
  logic [3:0] osrLog_r;
  logic [3:0] sinc3Log;
  logic [3:0] sinc1Log;

  // taking the setting only in standby keeps a running decimation coherent
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      osrLog_r <= mod_clock_pkg::OSR_LOG_MIN;
    end else if (standby) begin
      osrLog_r <= turboSelect ? mod_clock_pkg::OSR_LOG_TURBO
                              : mod_clock_pkg::OSR_LOG_MIN + {1'b0, osrSelect};
    end
  end

  assign sinc3Log = (osrLog_r > mod_clock_pkg::SINC3_LOG_MAX) ? mod_clock_pkg::SINC3_LOG_MAX
                                                                : osrLog_r;
  assign sinc1Log = osrLog_r - sinc3Log;

  // rate = measured frequency shifted down by log2 of the ratio
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      outputRateSps <= '0;
    end else begin
      outputRateSps <= mod_clock_pkg::RATE_W'(
        (32'(modulatorFrequencyKhz) * mod_clock_pkg::KHZ_TO_HZ) >> osrLog_r);
    end
  end

  // ==========================================================
  // decimation timing
  logic [mod_clock_pkg::CNT_W-1:0] modCount_r;
  logic [mod_clock_pkg::CNT_W-1:0] mask3;
  logic [mod_clock_pkg::CNT_W-1:0] maskAll;
  logic running;
  logic sinc3Point;
  logic convDone;

  assign running = ~standby;
  assign mask3 = lowMask(sinc3Log);
  assign maskAll = lowMask(osrLog_r);
  assign sinc3Point = modTick & running & ((modCount_r & mask3) == mask3);
  assign convDone = modTick & running & (modCount_r == maskAll);

  always_ff @(posedge clk_sys) begin
    if (!resetn || standby) begin
      modCount_r <= '0;
    end else if (modTick) begin
      modCount_r <= convDone ? '0 : modCount_r + 1'b1;
    end
  end

  // ==========================================================
  // per-channel sinc3 (integrator/comb), sinc1 and fast path
  logic [mod_clock_pkg::INT_W-1:0] int1_r [CH];
  logic [mod_clock_pkg::INT_W-1:0] int2_r [CH];
  logic [mod_clock_pkg::INT_W-1:0] int3_r [CH];
  logic [mod_clock_pkg::INT_W-1:0] dly1_r [CH];
  logic [mod_clock_pkg::INT_W-1:0] dly2_r [CH];
  logic [mod_clock_pkg::INT_W-1:0] dly3_r [CH];
  logic [mod_clock_pkg::INT_W-1:0] comb1 [CH];
  logic [mod_clock_pkg::INT_W-1:0] comb2 [CH];
  logic [mod_clock_pkg::INT_W-1:0] comb3 [CH];
  logic [mod_clock_pkg::ACC_W-1:0] sinc1Acc_r [CH];
  logic [mod_clock_pkg::ACC_W-1:0] sinc1Sum [CH];
  logic [mod_clock_pkg::FAST_W-1:0] fastAcc_r [CH];
  logic [mod_clock_pkg::FAST_W-1:0] fastSum [CH];
  logic [CH*WW-1:0] convWords;
  mod_clock_pkg::filter_path_e filterPath_r;

  // wrap-around arithmetic is exact as long as the modulus exceeds ratio cubed
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      comb1[c] = int3_r[c] - dly1_r[c];
      comb2[c] = comb1[c] - dly2_r[c];
      comb3[c] = comb2[c] - dly3_r[c];
      sinc1Sum[c] = sinc1Acc_r[c] + mod_clock_pkg::ACC_W'(comb3[c]);
      fastSum[c] = fastAcc_r[c] + mod_clock_pkg::FAST_W'(bitSync_r[c]);
    end
  end

  // integrators run on every modulator cycle while not in standby
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < CH; c++) begin
      if (!resetn) begin
        int1_r[c] <= '0;
        int2_r[c] <= '0;
        int3_r[c] <= '0;
      end else if (modTick && running) begin
        int1_r[c] <= int1_r[c] + mod_clock_pkg::INT_W'(bitSync_r[c]);
        int2_r[c] <= int2_r[c] + int1_r[c];
        int3_r[c] <= int3_r[c] + int2_r[c];
      end
    end
  end

  // combs at the sinc3 rate, capped at 1024 for the long ratios
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < CH; c++) begin
      if (!resetn) begin
        dly1_r[c] <= '0;
        dly2_r[c] <= '0;
        dly3_r[c] <= '0;
      end else if (sinc3Point) begin
        dly1_r[c] <= int3_r[c];
        dly2_r[c] <= comb1[c];
        dly3_r[c] <= comb2[c];
      end
    end
  end

  // sinc1 sums sinc3 results, fast path counts ones over the whole ratio
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < CH; c++) begin
      if (!resetn || standby) begin
        sinc1Acc_r[c] <= '0;
        fastAcc_r[c] <= '0;
      end else begin
        if (sinc3Point) begin
          sinc1Acc_r[c] <= convDone ? '0 : sinc1Sum[c];
        end
        if (modTick) begin
          fastAcc_r[c] <= convDone ? '0 : fastSum[c];
        end
      end
    end
  end

  // pick the path and bring each result to 24 bits
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      if (filterPath_r == mod_clock_pkg::FILT_FAST) begin
        convWords[c*WW +: WW] = scaleWord(mod_clock_pkg::ACC_W'(fastSum[c]),
                                          mod_clock_pkg::FULL_SCALE_LOG - {2'h0, osrLog_r});
      end else begin
        convWords[c*WW +: WW] = scaleWord(sinc1Sum[c], mod_clock_pkg::FULL_SCALE_LOG -
                                          6'(3 * sinc3Log) - {2'h0, sinc1Log});
      end
    end
  end

  // ==========================================================
  // filter path selection after reset
  logic [1:0] fastCount_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      filterPath_r <= mod_clock_pkg::FILT_FAST;
      fastCount_r <= 2'h0;
    end else if (convDone) begin
      unique case (filterPath_r)
        mod_clock_pkg::FILT_FAST: begin
          fastCount_r <= fastCount_r + 2'h1;
          if (fastCount_r == mod_clock_pkg::FAST_CONVERSIONS - 2'h1) begin
            filterPath_r <= mod_clock_pkg::FILT_SINC3;
          end
        end
        mod_clock_pkg::FILT_SINC3: begin
          filterPath_r <= mod_clock_pkg::FILT_SINC3;
        end
      endcase
    end
  end
  assign filterSettled = (filterPath_r == mod_clock_pkg::FILT_SINC3);

  // ==========================================================
  // hand-off register into the sample FIFO
  logic pend_r;
  logic [mod_clock_pkg::SAMPLE_W-1:0] pendData_r;
  logic fifoInReady;

  // conversions cannot be paused, so a full FIFO shows up as an overrun
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      pendData_r <= '0;
      sampleOverrun <= 1'b0;
    end else begin
      if (convDone) begin
        pend_r <= 1'b1;
        pendData_r <= {~filterSettled, convWords};
        if (pend_r && !fifoInReady) begin
          sampleOverrun <= 1'b1;
        end
      end else if (fifoInReady) begin
        pend_r <= 1'b0;
      end
    end
  end

  sample_fifo #(
    .WIDTH(mod_clock_pkg::SAMPLE_W),
    .DEPTH(mod_clock_pkg::FIFO_DEPTH)
  ) sampleBuffer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(pend_r),
    .inReady(fifoInReady),
    .inData(pendData_r),
    .outValid(sampleValid),
    .outReady(sampleReady),
    .outData(sampleData)
  );

endmodule : modulator_clock_and_decimation_control
`default_nettype wire

// ---- core/mod_clock_pkg.sv ----
package mod_clock_pkg;

  // ==========================================================
  // sizes
  localparam int CHANNELS = 3;
  localparam int WORD_W = 24;
  localparam int SAMPLE_W = CHANNELS * WORD_W + 1;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 14;
  localparam int INT_W = 32;
  localparam int ACC_W = 37;
  localparam int FAST_W = 15;
  localparam int KHZ_W = 13;
  localparam int RATE_W = 23;
  localparam int MEAS_W = 17;

  // ==========================================================
  // timing
  localparam int CLK_SYS_MHZ = 125;
  localparam int MEAS_WINDOW_US = 1000;
  localparam int MEAS_WINDOW_CYC = CLK_SYS_MHZ * MEAS_WINDOW_US;
  localparam int KHZ_TO_HZ = 1000;

  // ==========================================================
  // configuration codes
  localparam int PWR_HR_BIT = 1;
  localparam logic [2:0] HALF_DIV [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  localparam logic [3:0] OSR_LOG_MIN = 4'h7;
  localparam logic [3:0] OSR_LOG_TURBO = 4'h6;
  localparam logic [3:0] SINC3_LOG_MAX = 4'hA;
  localparam logic [5:0] FULL_SCALE_LOG = 6'h24;
  localparam logic [1:0] FAST_CONVERSIONS = 2'h2;

  // band edges in kHz, index is the band code
  localparam logic [KHZ_W-1:0] BAND_HIGH_KHZ [16] = '{
    13'h1004, 13'hEB8, 13'hD26, 13'hBE1, 13'hAD5, 13'h9F5, 13'h936, 13'h892,
    13'h803, 13'h786, 13'h717, 13'h6B4, 13'h65B, 13'h60B, 13'h5C3, 13'h581};
  localparam logic [KHZ_W-1:0] BAND_LOW_KHZ [16] = '{
    13'hEB8, 13'hD26, 13'hBE1, 13'hAD5, 13'h9F5, 13'h936, 13'h892, 13'h803,
    13'h786, 13'h717, 13'h6B4, 13'h65B, 13'h60B, 13'h5C3, 13'h581, 13'h578};

  typedef enum logic {FILT_FAST, FILT_SINC3} filter_path_e;

endpackage : mod_clock_pkg

// ---- core/sample_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  logic full;
  logic empty;

  // ==========================================================
  // flags: extra pointer bit tells full from empty
  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = mem[rdPtr_r[AW-1:0]];

  // storage has no reset, only pointers matter
  always_ff @(posedge clk_sys) begin
    if (inValid && !full) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // write pointer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrPtr_r <= '0;
    end else if (inValid && !full) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdPtr_r <= '0;
    end else if (outReady && !empty) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

endmodule : sample_fifo
`default_nettype wire

// ---- dv/mod_clock_tb_pkg.sv ----
package mod_clock_tb_pkg;

  // ==========================================================
  // band edges in kHz, fastest first: band n spans [n+1] up to [n]
  localparam logic [12:0] EDGE_KHZ [17] = '{
    13'h1004, 13'hEB8, 13'hD26, 13'hBE1, 13'hAD5, 13'h9F5, 13'h936, 13'h892, 13'h803,
    13'h786, 13'h717, 13'h6B4, 13'h65B, 13'h60B, 13'h5C3, 13'h581, 13'h578};

endpackage : mod_clock_tb_pkg

// ---- dv/mod_clock_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module mod_clock_checker #(
  parameter int MEAS_CYCLES = 1000
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic mainClockIn,
  input wire logic [2:0] modulatorBitIn,
  input wire logic [1:0] powerModeSelect,
  input wire logic [3:0] supplyBandCode,
  input wire logic [2:0] osrSelect,
  input wire logic turboSelect,
  input wire logic standby,
  input wire logic modulatorClock,
  input wire logic [2:0] modulatorBits,
  input wire logic highResolutionMode,
  input wire logic lowPowerMode,
  input wire logic [12:0] supplyBandLowKhz,
  input wire logic [12:0] supplyBandHighKhz,
  input wire logic [12:0] modulatorFrequencyKhz,
  input wire logic supplySyncMismatch,
  input wire logic [22:0] outputRateSps,
  input wire logic filterSettled,
  input wire logic sampleOverrun,
  input wire logic sampleValid
);
  // ==========================================================
  // own synchronisers, so edges line up with the design's view
  logic [2:0] mainSync_r;
  logic [5:0] bitSync_r;
  logic [31:0] rateExp;
  always_ff @(posedge clk_sys) begin
    mainSync_r <= {mainSync_r[1:0], mainClockIn};
    bitSync_r <= {bitSync_r[2:0], modulatorBitIn};
  end
  // rate from measured frequency; turbo wins over the field
  always_comb rateExp = (32'(modulatorFrequencyKhz) * 32'h3E8) >> (turboSelect ? 6 : 7 + osrSelect);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // properties
  chk_mode_follow: assert property ($past(resetn) |-> highResolutionMode == $past(powerModeSelect[1])) else $error("power mode output wrong");
  chk_mode_pair: assert property (lowPowerMode != highResolutionMode) else $error("power modes not exclusive");
  chk_band_limits: assert property ($past(resetn) |-> supplyBandHighKhz == mod_clock_tb_pkg::EDGE_KHZ[$past(supplyBandCode)] && supplyBandLowKhz == mod_clock_tb_pkg::EDGE_KHZ[int'($past(supplyBandCode)) + 1]) else $error("band limits wrong");
  chk_tick_source: assert property ($changed(modulatorClock) |-> $past(mainSync_r[1] & ~mainSync_r[2]) || $past(mainSync_r[1] & ~mainSync_r[2], 2)) else $error("modulator clock moved without main edge");
  chk_bits_hold: assert property ($changed(modulatorBits) |-> $rose(modulatorClock)) else $error("bits changed off tick");
  chk_bits_sample: assert property ($rose(modulatorClock) |-> modulatorBits == $past(bitSync_r[5:3])) else $error("bits not sampled at tick");
  chk_rate_calc: assert property ((standby && $stable(osrSelect) && $stable(turboSelect) && $stable(modulatorFrequencyKhz))[*3] |-> outputRateSps == rateExp[22:0]) else $error("output rate wrong");
  chk_idle_standby: assert property (standby[*4] |-> !$rose(sampleValid)) else $error("word made in standby");
  chk_settled_keep: assert property (filterSettled |=> filterSettled) else $error("filter left sinc3 path");
  chk_overrun_keep: assert property (sampleOverrun |=> sampleOverrun) else $error("overrun flag dropped");
  chk_sync_flag: assert property ($past(resetn) |-> supplySyncMismatch == ($past(modulatorFrequencyKhz) < $past(supplyBandLowKhz) || $past(modulatorFrequencyKhz) > $past(supplyBandHighKhz))) else $error("sync mismatch wrong");
  cover property ($rose(sampleValid));
  cover property ($rose(filterSettled));
  cover property ($rose(sampleOverrun));
  cover property (turboSelect && standby);
endmodule : mod_clock_checker

bind modulator_clock_and_decimation_control mod_clock_checker #(.MEAS_CYCLES(MEAS_CYCLES)) i_mod_clock_checker (
  .clk_sys(clk_sys), .resetn(resetn), .mainClockIn(mainClockIn), .modulatorBitIn(modulatorBitIn),
  .powerModeSelect(powerModeSelect), .supplyBandCode(supplyBandCode), .osrSelect(osrSelect),
  .turboSelect(turboSelect), .standby(standby), .modulatorClock(modulatorClock),
  .modulatorBits(modulatorBits), .highResolutionMode(highResolutionMode),
  .lowPowerMode(lowPowerMode), .supplyBandLowKhz(supplyBandLowKhz),
  .supplyBandHighKhz(supplyBandHighKhz), .modulatorFrequencyKhz(modulatorFrequencyKhz),
  .supplySyncMismatch(supplySyncMismatch), .outputRateSps(outputRateSps),
  .filterSettled(filterSettled), .sampleOverrun(sampleOverrun), .sampleValid(sampleValid));
`default_nettype wire

// ---- dv/host_clock_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_clock_model #(
  parameter int HALF = 5
) (
  input wire logic clk_sys,
  input wire logic [2:0] bitPattern,
  output logic mainClockIn,
  output logic [2:0] modulatorBitIn
);
  logic [7:0] count_r;
  initial begin
    count_r = 8'h0;
    mainClockIn = 1'b0;
    modulatorBitIn = 3'h0;
  end
  // main clock free-runs, never stopped, at a scaled rate
  always @(posedge clk_sys) begin
    if (count_r == 8'(HALF - 1)) begin
      count_r <= 8'h0;
      mainClockIn <= ~mainClockIn;
      // new bits launched on the falling main edge, far from the sampling rise
      if (mainClockIn) begin
        modulatorBitIn <= bitPattern;
      end
    end else begin
      count_r <= count_r + 8'h1;
    end
  end
endmodule : host_clock_model
`default_nettype wire

// ---- dv/test_modulator_clock_and_decimation_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_modulator_clock_and_decimation_control;
  localparam int MEAS = 1000;
  localparam int HALF = 2;
  localparam int CONV = 64 * 2 * 2 * HALF; // turbo ratio times modulator period
  localparam int LONG = 2048 * 2 * 2 * HALF; // first ratio with the sinc1 stage
  logic clk_sys, resetn, standby, turboSelect, sampleReady, modulatorClock, mainClockIn;
  logic highResolutionMode, lowPowerMode, supplySyncMismatch, filterSettled, sampleOverrun;
  logic sampleValid;
  logic [2:0] modulatorBitIn, bitPattern, osrSelect, modulatorBits;
  logic [1:0] powerModeSelect, dividerSelect;
  logic [3:0] supplyBandCode;
  logic [12:0] bandLow, bandHigh, freqKhz;
  logic [22:0] rateSps;
  logic [72:0] sampleData;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  modulator_clock_and_decimation_control #(.MEAS_CYCLES(MEAS)) i_modulator_clock_and_decimation_control (
    .clk_sys(clk_sys), .resetn(resetn), .mainClockIn(mainClockIn), .modulatorBitIn(modulatorBitIn),
    .powerModeSelect(powerModeSelect), .dividerSelect(dividerSelect),
    .supplyBandCode(supplyBandCode), .osrSelect(osrSelect), .turboSelect(turboSelect),
    .standby(standby), .modulatorClock(modulatorClock), .modulatorBits(modulatorBits),
    .highResolutionMode(highResolutionMode), .lowPowerMode(lowPowerMode),
    .supplyBandLowKhz(bandLow), .supplyBandHighKhz(bandHigh), .modulatorFrequencyKhz(freqKhz),
    .supplySyncMismatch(supplySyncMismatch), .outputRateSps(rateSps),
    .filterSettled(filterSettled), .sampleOverrun(sampleOverrun), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData));
  host_clock_model #(.HALF(HALF)) i_host_clock_model (
    .clk_sys(clk_sys), .bitPattern(bitPattern), .mainClockIn(mainClockIn),
    .modulatorBitIn(modulatorBitIn));

  // ==========================================================
  // clock, hang guard and shared tasks
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // the longest scenario is the long-ratio pair, about 33k cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // bounded waits: a stuck clock or empty buffer gives up and shows as a mismatch
  task automatic wait_level(input logic lvl, output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (modulatorClock !== lvl && n < 2000);
  endtask : wait_level
  task automatic wait_valid(output int n);
    n = 0;
    while (sampleValid !== 1'b1 && n < 2 * LONG) begin
      step(1);
      n++;
    end
  endtask : wait_valid

  // ==========================================================
  // scenarios
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      powerModeSelect = 2'(m);
      step(2);
      check(highResolutionMode, m[1]);
      check(lowPowerMode, !m[1]);
    end
    for (int c = 0; c < 16; c++) begin
      supplyBandCode = 4'(c);
      step(2);
      check(bandHigh, mod_clock_tb_pkg::EDGE_KHZ[c]);
      check(bandLow, mod_clock_tb_pkg::EDGE_KHZ[c + 1]);
    end
    supplyBandCode = 4'h8;
  endtask : t_modes
  task automatic t_divider;
    int ratio [4] = '{2, 4, 8, 12};
    int hi, lo;
    for (int d = 0; d < 4; d++) begin
      dividerSelect = 2'(d);
      wait_level(1'b1, hi);
      wait_level(1'b0, hi);
      wait_level(1'b1, lo);
      wait_level(1'b0, hi);
      wait_level(1'b1, lo);
      check(hi, ratio[d] * HALF);
      check(hi + lo, 2 * ratio[d] * HALF);
    end
    dividerSelect = 2'h0;
  endtask : t_divider
  task automatic t_rate;
    step(2 * MEAS + 50);
    check(freqKhz, MEAS / (4 * HALF));
    check(supplySyncMismatch, 1'b1);
    // field changes only while in standby
    for (int s = 0; s < 9; s++) begin
      turboSelect = (s == 8);
      osrSelect = 3'(s);
      step(4);
      check(rateSps, (MEAS / (4 * HALF) * 1000) >> (s == 8 ? 6 : 7 + s));
    end
  endtask : t_rate
  task automatic t_convert;
    int n;
    bitPattern = 3'h5;
    sampleReady = 1'b1;
    step(300);
    standby = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wait_valid(n);
      check(sampleData[72], k < 2);
      if (k < 2) check(sampleData[71:0] == {24'hFFFFFF, 24'h0, 24'hFFFFFF}, 1);
      if (k > 0) check(n + 1, CONV);
      step(1);
    end
    check(filterSettled, 1'b1);
  endtask : t_convert
  task automatic t_fifo;
    int n;
    sampleReady = 1'b0;
    wait_valid(n);
    step(30 * CONV + 100);
    check(sampleOverrun, 1'b0);
    step(3 * CONV);
    check(sampleOverrun, 1'b1);
    standby = 1'b1;
    sampleReady = 1'b1;
    n = 0;
    while (sampleValid === 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    check(n, mod_clock_pkg::FIFO_DEPTH + 1);
  endtask : t_fifo
  task automatic t_long;
    int n;
    turboSelect = 1'b0;
    osrSelect = 3'h4;
    step(2);
    standby = 1'b0;
    for (int k = 0; k < 2; k++) begin
      wait_valid(n);
      check(sampleData[72], 1'b0);
      check(sampleData[47:24], 24'h0);
      if (k > 0) check(n + 1, LONG);
      step(1);
    end
  endtask : t_long

  initial begin
    resetn = 1'b0;
    standby = 1'b1;
    turboSelect = 1'b0;
    sampleReady = 1'b0;
    bitPattern = 3'h0;
    osrSelect = 3'h0;
    powerModeSelect = 2'h0;
    dividerSelect = 2'h0;
    supplyBandCode = 4'h0;
    repeat (6) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    step(1);
    check(lowPowerMode, 1'b1);
    check(sampleValid, 1'b0);
    check(filterSettled, 1'b0);
    t_modes();
    t_divider();
    t_rate();
    t_convert();
    t_fifo();
    t_long();
    end_of_test();
  end
endmodule : test_modulator_clock_and_decimation_control
`default_nettype wire
